// ---- svdc_analog_model.sv ----
// analog comparator and free-running timebase seen by the detector
`timescale 1ns/100ps
module svdc_analog_model (
  // from the detector
  input  wire logic       detectorPowerEn,
  input  wire logic [3:0] tripLevelSel,
  input  wire logic       externalInputSel,
  // stimulus from the bench
  input  wire logic [4:0] supplyStep,
  input  wire logic       extAbove,
  // to the detector
  output logic            cmpAtOrAbove,
  output logic            timebasePin
);
  initial timebasePin = 1'b0;
  // runs free and unrelated in phase to mclk
  always #37 timebasePin = ~timebasePin;
  // equality counts as at or above; code 1111 takes the external input
  // a powered-down comparator is meaningless, so its output wanders
  assign cmpAtOrAbove = !detectorPowerEn ? timebasePin
    : externalInputSel ? extAbove : (supplyStep >= {1'b0, tripLevelSel});
endmodule // svdc_analog_model

// ---- svdc_det_if.sv ----
// control and status signals between the detector top and its helpers
`timescale 1ns/100ps
interface svdc_det_if;
  logic enable;
  logic direction;
  logic restart;
  logic stable;
  logic trip;

  modport ctl (output enable, output direction, output restart, input stable, input trip);
  modport tmr (input enable, input restart, output stable);
  modport det (input direction, input stable, output trip);
endinterface

// ---- svdc_event_detect.sv ----
// comparator synchroniser and crossing qualifier
`timescale 1ns/100ps
module svdc_event_detect (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // analog comparator, high while monitored voltage is at or above trip
  input  wire logic cmpAtOrAbove,
  // to the detector top
  svdc_det_if.det   ctl
);

  logic cmpMeta_reg;
  logic cmpSync_reg;
  wire  crossed;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmpMeta_reg <= 1'b0;
      cmpSync_reg <= 1'b0;
    end
    else
    begin
      cmpMeta_reg <= cmpAtOrAbove;
      cmpSync_reg <= cmpMeta_reg;
    end
  end

  assign crossed = ctl.direction ? cmpSync_reg : ~cmpSync_reg;

  assign ctl.trip = crossed & ctl.stable;

endmodule // svdc_event_detect

// ---- svdc_pkg.sv ----
// constants shared by the supply voltage detect control block
package svdc_pkg;

  // register byte addresses on the AXI4-Lite port
  localparam logic [7:0] OFS_DET_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PER_FLAGS  = 8'h04;
  localparam logic [7:0] OFS_PER_ENA    = 8'h08;
  localparam logic [7:0] OFS_PER_PRIO   = 8'h0c;
  localparam logic [7:0] OFS_INT_GLOBAL = 8'h10;

  // detector_control fields
  localparam int          CTRL_DIR_BIT    = 7;
  localparam int          CTRL_STABLE_BIT = 5;
  localparam int          CTRL_EN_BIT     = 4;
  localparam int          CTRL_LVL_MSB    = 3;
  localparam int          CTRL_LVL_LSB    = 0;
  localparam logic [7:0]  CTRL_RESET      = 8'h05;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'h9f;

  // trip level code that routes the external input to the comparator
  localparam logic [3:0]  LVL_EXTERNAL    = 4'hf;

  // detector bit position in the peripheral flag, enable and priority registers
  localparam int          DET_BIT         = 2;
  // global interrupt enable position in interrupt_global_control
  localparam int          GIE_BIT         = 7;
  localparam logic        PRIO_RESET      = 1'b1;

  // AXI4-Lite responses
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // reference settling interval in ticks of the independent timebase
  localparam int          SETTLE_TICKS    = 4;
  localparam int          SETTLE_CNT_W    = 8;

endpackage

// ---- svdc_settle_timer.sv ----
// reference settling timer counted on an independent timebase
`timescale 1ns/100ps
module svdc_settle_timer #(
  parameter int TICKS = svdc_pkg::SETTLE_TICKS
) (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // free-running timebase pin, asynchronous to mclk
  input  wire logic timebasePin,
  // to the detector top
  svdc_det_if.tmr   ctl
);

  logic                            tbMeta_reg;
  logic                            tbSync_reg;
  logic                            tbLast_reg;
  logic [svdc_pkg::SETTLE_CNT_W-1:0] count_reg;
  logic                            done_reg;
  wire                             tick;
  wire                             atEnd;

  assign tick  = tbSync_reg & ~tbLast_reg;
  assign atEnd = (count_reg == svdc_pkg::SETTLE_CNT_W'(TICKS - 1));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tbMeta_reg <= 1'b0;
      tbSync_reg <= 1'b0;
      tbLast_reg <= 1'b0;
    end
    else
    begin
      tbMeta_reg <= timebasePin;
      tbSync_reg <= tbMeta_reg;
      tbLast_reg <= tbSync_reg;
    end
  end

  // count timebase ticks
  // the interval depends on the timebase only, not on mclk
  // restart on re-enable
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end
    else if (!ctl.enable || ctl.restart)
    begin
      count_reg <= '0;
      done_reg  <= 1'b0;
    end
    else if (tick && !done_reg)
    begin
      count_reg <= count_reg + svdc_pkg::SETTLE_CNT_W'(1);
      done_reg  <= atEnd;
    end
  end

  assign ctl.stable = done_reg & ctl.enable;

endmodule // svdc_settle_timer

// ---- svdc_tb_top.sv ----
// self-checking bench for the supply voltage detect control block
`timescale 1ns/100ps
module svdc_tb_top;
  logic        mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cmpAtOrAbove, timebasePin, refShareCycled;
  logic        detectorPowerEn, externalInputSel, wakeRequest, intRequest;
  logic        intHighPriority, extAbove;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb, tripLevelSel;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  supplyStep;
  int          n_errors, n_compared, seed, k;
  int          m[5];
  int          mask[5] = '{8'h9f, 8'h04, 8'h04, 8'h04, 8'h80};
  int          rstVal[5] = '{8'h05, 8'h00, 8'h00, 8'h04, 8'h00};

  svdc_top #(.ADDR_W(8), .SETTLE_TICKS(2)) uut (.*);
  svdc_analog_model analog (.*);

  always #2 mclk = ~mclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, dat};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge mclk);
      aw |= s_axi_awvalid && s_axi_awready;
      w |= s_axi_wvalid && s_axi_wready;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    while (!s_axi_bvalid) @(posedge mclk);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'(er));
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check(32'(s_axi_rresp), 32'(er));
    @(posedge mclk);
  endtask

  task automatic mw(input int i, input logic [7:0] d);
    wr(8'(i * 4), d, svdc_pkg::RESP_OKAY);
    m[i] = d & mask[i];
  endtask

  task automatic rdc(input int i, input logic [7:0] e);
    logic [31:0] d;
    rd(8'(i * 4), d, svdc_pkg::RESP_OKAY);
    check(d, {24'h0, e});
  endtask

  // polls until the reference reports stable, bounded
  task automatic settle();
    rdv = '0;
    for (int j = 0; j < 60 && !rdv[5]; j++) rd(8'h00, rdv, svdc_pkg::RESP_OKAY);
  endtask

  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    n_errors++;
    summarize();
  end

  initial
  begin
    seed = 32'he3551317;
    mclk = 1'b0;
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, refShareCycled, extAbove, supplyStep} = '0;
    s_axi_wstrb = 4'h1;
    {n_errors, n_compared} = '0;
    m = rstVal;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (k = 0; k < 5; k++) rdc(k, 8'(m[k]));
    rd(8'h14, rdv, svdc_pkg::RESP_SLVERR);
    check(rdv, 32'h0);
    wr(8'h14, 8'hff, svdc_pkg::RESP_SLVERR);
    // write without lane 0 must leave the register alone
    s_axi_wstrb <= 4'he;
    wr(8'h00, 8'h9f, svdc_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    rdc(0, 8'(m[0]));
    for (k = 0; k < 16; k++)
    begin
      mw(0, 8'($random(seed)) & 8'h80 | 8'h60 | 8'(k));
      rdc(0, 8'(m[0]));
      check(32'(tripLevelSel), 32'(k));
      check(32'(externalInputSel), 32'(k == 15));
    end
    // rising watch, reached exactly at the threshold
    supplyStep <= 5'd3;
    mw(0, 8'h08);
    mw(0, 8'h88);
    mw(0, 8'h98);
    rdc(0, 8'(m[0]));
    settle();
    rdc(0, 8'(m[0]) | 8'h20);
    mw(1, 8'h00);
    mw(2, 8'h04);
    mw(4, 8'h80);
    check(32'(wakeRequest), 32'h0);
    supplyStep <= 5'd8;
    repeat (6) @(posedge mclk);
    rdc(1, 8'h04);
    check(32'(wakeRequest), 32'h1);
    check(32'(intRequest), 32'h1);
    mw(4, 8'h00);
    check(32'(intRequest), 32'h0);
    check(32'(wakeRequest), 32'h1);
    mw(1, 8'h00);
    rdc(1, 8'h04);
    supplyStep <= 5'd3;
    repeat (6) @(posedge mclk);
    mw(1, 8'h00);
    rdc(1, 8'(m[1]));
    // falling watch after a disable
    // detector off between checks
    mw(0, 8'h08);
    rdc(0, 8'(m[0]));
    check(32'(detectorPowerEn), 32'h0);
    mw(0, 8'h18);
    settle();
    repeat (6) @(posedge mclk);
    rdc(1, 8'h04);
    supplyStep <= 5'd12;
    repeat (6) @(posedge mclk);
    mw(1, 8'h00);
    rdc(1, 8'(m[1]));
    // software sets the flag so a pending interrupt meets an unstable reference
    mw(4, 8'h80);
    mw(1, 8'h04);
    check(32'(intRequest), 32'h1);
    refShareCycled <= 1'b1;
    repeat (6) @(posedge mclk);
    check(32'(intRequest), 32'h0);
    check(32'(wakeRequest), 32'h1);
    rdc(0, 8'(m[0]));
    refShareCycled <= 1'b0;
    settle();
    rdc(0, 8'(m[0]) | 8'h20);
    // internal divider would trip here, so only the external input may decide
    supplyStep <= 5'd31;
    mw(0, 8'h0f);
    mw(0, 8'h8f);
    mw(0, 8'h9f);
    check(32'(externalInputSel), 32'h1);
    settle();
    mw(1, 8'h00);
    rdc(1, 8'(m[1]));
    extAbove <= 1'b1;
    repeat (6) @(posedge mclk);
    rdc(1, 8'h04);
    mw(3, 8'h00);
    check(32'(intHighPriority), 32'h0);
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    m = rstVal;
    for (k = 0; k < 5; k++) rdc(k, 8'(m[k]));
    check(32'(detectorPowerEn), 32'h0);
    check(32'(intHighPriority), 32'h1);
    summarize();
  end
endmodule // svdc_tb_top

// ---- svdc_top.sv ----
// supply voltage detect control: register file, AXI4-Lite slave, event flag
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps

module svdc_top #(
  parameter int ADDR_W       = 8,
  parameter int SETTLE_TICKS = svdc_pkg::SETTLE_TICKS
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analog side
  input  wire logic              cmpAtOrAbove,
  input  wire logic              timebasePin,
  input  wire logic              refShareCycled,
  output logic                   detectorPowerEn,
  output logic [3:0]             tripLevelSel,
  output logic                   externalInputSel,
  // to the core
  output logic                   wakeRequest,
  output logic                   intRequest,
  output logic                   intHighPriority
);

  svdc_det_if detIf ();

  // registers
  logic [7:0]        ctrl_reg;
  logic              eventFlag_reg;
  logic              intEnable_reg;
  logic              intPrio_reg;
  logic              globalEnable_reg;
  logic              shareMeta_reg;
  logic              shareSync_reg;

  // bus state
  logic              awHeld_reg;
  logic              wHeld_reg;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [7:0]        wData_reg;
  logic              wLane_reg;

  // decode
  wire               awFire;
  wire               wFire;
  wire               arFire;
  wire               doWrite;
  wire               wrLane;
  wire               wrCtrl;
  wire               wrFlags;
  wire               wrEna;
  wire               wrPrio;
  wire               wrGlobal;
  wire               wrHit;
  wire               rdHit;
  wire [7:0]         rdByte;
  wire [7:0]         ctrlView;
  wire [7:0]         ctrl_next;
  wire               eventFlag_next;
  wire               intReq_next;
  wire               wake_next;

  function automatic logic hitAt(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hitAt = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = hitAt(a, svdc_pkg::OFS_DET_CTRL) | hitAt(a, svdc_pkg::OFS_PER_FLAGS)
             | hitAt(a, svdc_pkg::OFS_PER_ENA) | hitAt(a, svdc_pkg::OFS_PER_PRIO)
             | hitAt(a, svdc_pkg::OFS_INT_GLOBAL);
  endfunction

  // helpers
  svdc_settle_timer #(
    .TICKS       (SETTLE_TICKS)
  ) u_settle (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .timebasePin (timebasePin),
    .ctl         (detIf.tmr)
  );

  svdc_event_detect u_event (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .cmpAtOrAbove (cmpAtOrAbove),
    .ctl          (detIf.det)
  );

  assign detIf.enable    = ctrl_reg[svdc_pkg::CTRL_EN_BIT];
  assign detIf.direction = ctrl_reg[svdc_pkg::CTRL_DIR_BIT];
  assign detIf.restart   = shareSync_reg;

  // channel handshakes
  assign awFire  = s_axi_awvalid & s_axi_awready;
  assign wFire   = s_axi_wvalid & s_axi_wready;
  assign arFire  = s_axi_arvalid & s_axi_arready;
  assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

  // registers are 8 bits wide in byte lane 0; other lanes are ignored
  assign wrLane   = doWrite & wLane_reg;
  assign wrCtrl   = wrLane & hitAt(awAddr_reg, svdc_pkg::OFS_DET_CTRL);
  assign wrFlags  = wrLane & hitAt(awAddr_reg, svdc_pkg::OFS_PER_FLAGS);
  assign wrEna    = wrLane & hitAt(awAddr_reg, svdc_pkg::OFS_PER_ENA);
  assign wrPrio   = wrLane & hitAt(awAddr_reg, svdc_pkg::OFS_PER_PRIO);
  assign wrGlobal = wrLane & hitAt(awAddr_reg, svdc_pkg::OFS_INT_GLOBAL);
  assign wrHit    = isMapped(awAddr_reg);
  assign rdHit    = isMapped(s_axi_araddr);

  // stable bit read-only, bit 6 masked off
  assign ctrl_next = (wData_reg & svdc_pkg::CTRL_WR_MASK);

  assign ctrlView = {ctrl_reg[svdc_pkg::CTRL_DIR_BIT], 1'b0, detIf.stable,
                     ctrl_reg[svdc_pkg::CTRL_EN_BIT:0]};

  assign rdByte =
      hitAt(s_axi_araddr, svdc_pkg::OFS_DET_CTRL)   ? ctrlView :
      hitAt(s_axi_araddr, svdc_pkg::OFS_PER_FLAGS)  ? 8'(eventFlag_reg) << svdc_pkg::DET_BIT :
      hitAt(s_axi_araddr, svdc_pkg::OFS_PER_ENA)    ? 8'(intEnable_reg) << svdc_pkg::DET_BIT :
      hitAt(s_axi_araddr, svdc_pkg::OFS_PER_PRIO)   ? 8'(intPrio_reg) << svdc_pkg::DET_BIT :
      hitAt(s_axi_araddr, svdc_pkg::OFS_INT_GLOBAL) ? 8'(globalEnable_reg) << svdc_pkg::GIE_BIT :
      8'h00;

  // sticky flag; a trip in the clearing cycle wins
  // the detector keeps flagging whatever the core's power state
  assign eventFlag_next = detIf.trip
                        | (wrFlags ? wData_reg[svdc_pkg::DET_BIT] : eventFlag_reg);

  // wake does not need the global enable, the vector branch does
  assign wake_next   = eventFlag_reg & intEnable_reg;
  assign intReq_next = wake_next & detIf.stable & globalEnable_reg;

  // write address and data channels, taken in either order
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= '0;
      wData_reg  <= 8'h00;
      wLane_reg  <= 1'b0;
    end
    else
    begin
      if (awFire)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      else if (doWrite)
        awHeld_reg <= 1'b0;
      if (wFire)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata[7:0];
        wLane_reg <= s_axi_wstrb[0];
      end
      else if (doWrite)
        wHeld_reg <= 1'b0;
    end
  end

  // channel readies and write response
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= svdc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~awHeld_reg & ~awFire & ~s_axi_bvalid & ~doWrite;
      s_axi_wready  <= ~wHeld_reg & ~wFire & ~s_axi_bvalid & ~doWrite;
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? svdc_pkg::RESP_OKAY : svdc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel; data captured on the address handshake
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= svdc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~arFire;
      if (arFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rdByte};
        s_axi_rresp  <= rdHit ? svdc_pkg::RESP_OKAY : svdc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // reset returns every bit to its reset value, detector off
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg         <= svdc_pkg::CTRL_RESET;
      intEnable_reg    <= 1'b0;
      intPrio_reg      <= svdc_pkg::PRIO_RESET;
      globalEnable_reg <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
        ctrl_reg <= ctrl_next;
      if (wrEna)
        intEnable_reg <= wData_reg[svdc_pkg::DET_BIT];
      if (wrPrio)
        intPrio_reg <= wData_reg[svdc_pkg::DET_BIT];
      if (wrGlobal)
        globalEnable_reg <= wData_reg[svdc_pkg::GIE_BIT];
    end
  end

  // event flag and shared reference synchroniser
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eventFlag_reg <= 1'b0;
      shareMeta_reg <= 1'b0;
      shareSync_reg <= 1'b0;
    end
    else
    begin
      eventFlag_reg <= eventFlag_next;
      shareMeta_reg <= refShareCycled;
      shareSync_reg <= shareMeta_reg;
    end
  end

  // analog controls and core requests, all registered
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      detectorPowerEn  <= 1'b0;
      tripLevelSel     <= 4'h0;
      externalInputSel <= 1'b0;
      wakeRequest      <= 1'b0;
      intRequest       <= 1'b0;
      intHighPriority  <= 1'b0;
    end
    else
    begin
      detectorPowerEn  <= ctrl_reg[svdc_pkg::CTRL_EN_BIT];
      tripLevelSel     <= ctrl_reg[svdc_pkg::CTRL_LVL_MSB:svdc_pkg::CTRL_LVL_LSB];
      // top code takes the external pin
      externalInputSel <= (ctrl_reg[svdc_pkg::CTRL_LVL_MSB:svdc_pkg::CTRL_LVL_LSB]
                           == svdc_pkg::LVL_EXTERNAL);
      wakeRequest      <= wake_next;
      intRequest       <= intReq_next;
      intHighPriority  <= intPrio_reg;
    end
  end

endmodule // svdc_top

// ---- svdc_top_monitor.sv ----
// assertions on the supply voltage detect control ports
`timescale 1ns/100ps
module svdc_top_monitor (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // detector side
  input wire logic        detectorPowerEn,
  input wire logic [3:0]  tripLevelSel,
  input wire logic        externalInputSel,
  input wire logic        wakeRequest,
  input wire logic        intRequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_int_needs_wake: assert property (intRequest |-> wakeRequest)
    else $error("interrupt without wake request");
  a_off_no_int: assert property (!detectorPowerEn [*3] |-> !intRequest)
    else $error("interrupt while detector off");
  a_ext_select: assert property (
    externalInputSel == (tripLevelSel == svdc_pkg::LVL_EXTERNAL))
    else $error("external select does not follow level code");
  // flag and enable only drop through a register write
  a_flag_sticky: assert property ($fell(wakeRequest) |-> $past(s_axi_bvalid))
    else $error("wake request dropped without a write");
  a_level_by_write: assert property (
    $past(rst_n, 2) && $changed(tripLevelSel) |-> $past(s_axi_bvalid))
    else $error("trip level changed without a write");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_clean: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 &&
    (s_axi_rresp == svdc_pkg::RESP_OKAY || s_axi_rdata == 32'h0))
    else $error("read data not clean");

  c_irq: cover property (intRequest);
  c_flag_cleared: cover property ($fell(wakeRequest));
  c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == svdc_pkg::RESP_SLVERR);
endmodule // svdc_top_monitor

bind svdc_top svdc_top_monitor mon (.*);
